// ### pkg/irq_ctrl_defines.vh
// Notes on behaviour
// - Two 8-bit mask registers: pins, timers
// - Accepting an interrupt clears global enable
// - Return instruction sets global enable again
// - Vectoring clears the serviced source flag
// - Disabled source still sets its flag
// - Pending flags served by priority later
// - Low-level request has no latched flag
// - Status register never saved by hardware
// - Mask bit 7 enables pin 1, vector 0x002
// - Mask bit 6 enables pin 0, vector 0x001
// - Two sense bits per pin pick trigger
// - Pin activity detected even when output
// - Level mode: no flag, still requests
// - Flag bit 7 set by pin 1 edge
// - Flag bit 6 set by pin 0 edge
// - Edge flag held clear in level mode
// - Pin register bits 5..0 read zero
// - Timer mask bit 7: t1 overflow, 0x005
// - Timer mask bit 6: t1 compare, 0x004
// - Timer mask bit 3: t1 capture, 0x003
// - Timer mask bit 1: t0 overflow, 0x006
// - Timer flags at 7,6,3,1, write-one clears
// - Vector no sooner than four cycles after flag
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

`define ADDR_TIMER_IRQ_ENABLES 6'h39
`define ADDR_TIMER_IRQ_FLAG_REG 6'h38
`define ADDR_PIN_IRQ_ENABLES 6'h3B
`define ADDR_PIN_IRQ_FLAGS 6'h3A
`define ADDR_MCU_CONTROL_REG 6'h35
`define ADDR_CPU_STATUS_REG 6'h3F

`define BIT_EXT1 7
`define BIT_EXT0 6
`define BIT_T1_OVF 7
`define BIT_T1_CMP 6
`define BIT_T1_CAP 3
`define BIT_T0_OVF 1
`define BIT_GIE 7

`define PIN_MASK_BITS 8'hC0
`define TIMER_MASK_BITS 8'hCA
`define MCU_CTRL_BITS 8'h0F
`define RESET_BYTE 8'h00

`define SENSE_LOW 2'h0
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

`define VEC_EXT0 4'h1
`define VEC_EXT1 4'h2
`define VEC_T1_CAP 4'h3
`define VEC_T1_CMP 4'h4
`define VEC_T1_OVF 4'h5
`define VEC_T0_OVF 4'h6

`define RESPONSE_CYCLES 3'h4

`endif

// ### core/pin_and_timer_irq_control.v
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.vh"

module pin_and_timer_irq_control #(
  parameter ADDR_W = 6
) (
  // Clock, reset, enable
  input wire clock,
  input wire sys_rst,
  input wire clk_en,
  // Register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Event sources
  input wire ext_pin0,
  input wire ext_pin1,
  input wire t1_overflow_evt,
  input wire t1_compare_evt,
  input wire t1_capture_evt,
  input wire t0_overflow_evt,
  // Core side
  input wire core_irq_ack,
  input wire return_from_irq_instr,
  input wire instr_boundary,
  output reg core_irq_req,
  output reg [3:0] core_irq_vector
);

  reg [7:0] pin_irq_enables;
  reg [7:0] timer_irq_enables;
  reg [7:0] mcu_control_reg;
  reg ext_req1_flag;
  reg ext_req0_flag;
  reg t1_overflow_flag;
  reg t1_compare_flag;
  reg t1_capture_flag;
  reg t0_overflow_flag;
  reg global_enable;
  reg pin0_prev;
  reg pin1_prev;
  reg [2:0] age0;
  reg [2:0] age1;
  reg [2:0] age_cap;
  reg [2:0] age_cmp;
  reg [2:0] age_ovf1;
  reg [2:0] age_ovf0;
  reg [2:0] age_lvl0;
  reg [2:0] age_lvl1;

  wire [1:0] sense0 = mcu_control_reg[1:0];
  wire [1:0] sense1 = mcu_control_reg[3:2];
  wire lvl0 = (sense0 == `SENSE_LOW);
  wire lvl1 = (sense1 == `SENSE_LOW);

  function edge_hit;
    input [1:0] sense;
    input prev;
    input cur;
    begin
      edge_hit = ((sense == `SENSE_FALL) && prev && !cur) ||
        ((sense == `SENSE_RISE) && !prev && cur);
    end
  endfunction

  wire edge0 = edge_hit(sense0, pin0_prev, ext_pin0);
  wire edge1 = edge_hit(sense1, pin1_prev, ext_pin1);

  wire wr_pin_flags = reg_wr && (reg_addr == `ADDR_PIN_IRQ_FLAGS);
  wire wr_tmr_flags = reg_wr && (reg_addr == `ADDR_TIMER_IRQ_FLAG_REG);

  wire lvl0_req = lvl0 && !ext_pin0;
  wire lvl1_req = lvl1 && !ext_pin1;

  wire ready_ext0 = lvl0 ? (lvl0_req && age_lvl0 >= `RESPONSE_CYCLES)
    : (ext_req0_flag && age0 >= `RESPONSE_CYCLES);
  wire ready_ext1 = lvl1 ? (lvl1_req && age_lvl1 >= `RESPONSE_CYCLES)
    : (ext_req1_flag && age1 >= `RESPONSE_CYCLES);

  wire en_ext0 = ready_ext0 && pin_irq_enables[`BIT_EXT0];
  wire en_ext1 = ready_ext1 && pin_irq_enables[`BIT_EXT1];
  wire en_cap = t1_capture_flag && age_cap >= `RESPONSE_CYCLES &&
    timer_irq_enables[`BIT_T1_CAP];
  wire en_cmp = t1_compare_flag && age_cmp >= `RESPONSE_CYCLES &&
    timer_irq_enables[`BIT_T1_CMP];
  wire en_ovf1 = t1_overflow_flag && age_ovf1 >= `RESPONSE_CYCLES &&
    timer_irq_enables[`BIT_T1_OVF];
  wire en_ovf0 = t0_overflow_flag && age_ovf0 >= `RESPONSE_CYCLES &&
    timer_irq_enables[`BIT_T0_OVF];

  reg [3:0] next_vector;
  always @* begin
    if (en_ext0) begin
      next_vector = `VEC_EXT0;
    end else if (en_ext1) begin
      next_vector = `VEC_EXT1;
    end else if (en_cap) begin
      next_vector = `VEC_T1_CAP;
    end else if (en_cmp) begin
      next_vector = `VEC_T1_CMP;
    end else if (en_ovf1) begin
      next_vector = `VEC_T1_OVF;
    end else if (en_ovf0) begin
      next_vector = `VEC_T0_OVF;
    end else begin
      next_vector = 4'h0;
    end
  end

  wire any_ready = en_ext0 | en_ext1 | en_cap | en_cmp | en_ovf1 | en_ovf0;
  // grant only when enabled at a boundary
  wire next_req = global_enable && any_ready && instr_boundary &&
    !core_irq_ack;
  wire accept = core_irq_ack && core_irq_req;
  wire [3:0] acc_vec = core_irq_vector;

  function [2:0] age_step;
    input flag;
    input [2:0] age;
    begin
      if (!flag) begin
        age_step = 3'h0;
      end else if (age < `RESPONSE_CYCLES) begin
        age_step = age + 3'h1;
      end else begin
        age_step = age;
      end
    end
  endfunction

  // Clear requests: vectoring to the source or a one written by software
  wire clr_ext0 = (accept && acc_vec == `VEC_EXT0) ||
    (wr_pin_flags && reg_wdata[`BIT_EXT0]);
  wire clr_ext1 = (accept && acc_vec == `VEC_EXT1) ||
    (wr_pin_flags && reg_wdata[`BIT_EXT1]);
  wire clr_cap = (accept && acc_vec == `VEC_T1_CAP) ||
    (wr_tmr_flags && reg_wdata[`BIT_T1_CAP]);
  wire clr_cmp = (accept && acc_vec == `VEC_T1_CMP) ||
    (wr_tmr_flags && reg_wdata[`BIT_T1_CMP]);
  wire clr_ovf1 = (accept && acc_vec == `VEC_T1_OVF) ||
    (wr_tmr_flags && reg_wdata[`BIT_T1_OVF]);
  wire clr_ovf0 = (accept && acc_vec == `VEC_T0_OVF) ||
    (wr_tmr_flags && reg_wdata[`BIT_T0_OVF]);

  wire wr_pin_en = reg_wr && (reg_addr == `ADDR_PIN_IRQ_ENABLES);
  wire wr_tmr_en = reg_wr && (reg_addr == `ADDR_TIMER_IRQ_ENABLES);
  wire wr_mcu = reg_wr && (reg_addr == `ADDR_MCU_CONTROL_REG);
  wire wr_status = reg_wr && (reg_addr == `ADDR_CPU_STATUS_REG);

  // Read views with reserved bits tied to zero
  wire [7:0] pin_flag_view = {ext_req1_flag, ext_req0_flag, 6'h00};
  wire [7:0] tmr_flag_view = {t1_overflow_flag, t1_compare_flag, 2'h0,
    t1_capture_flag, 1'b0, t0_overflow_flag, 1'b0};
  wire [7:0] status_view = {global_enable, 7'h00};

  // Pin history for edge detection; idle level is high
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin0_prev <= 1'b1;
      pin1_prev <= 1'b1;
    end else if (clk_en) begin
      pin0_prev <= ext_pin0;
      pin1_prev <= ext_pin1;
    end
  end

  // pin request ages, saturating at four
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      age0 <= 3'h0;
      age1 <= 3'h0;
      age_lvl0 <= 3'h0;
      age_lvl1 <= 3'h0;
    end else if (clk_en) begin
      age0 <= age_step(ext_req0_flag, age0);
      age1 <= age_step(ext_req1_flag, age1);
      age_lvl0 <= age_step(lvl0_req, age_lvl0);
      age_lvl1 <= age_step(lvl1_req, age_lvl1);
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      age_cap <= 3'h0;
      age_cmp <= 3'h0;
      age_ovf1 <= 3'h0;
      age_ovf0 <= 3'h0;
    end else if (clk_en) begin
      age_cap <= age_step(t1_capture_flag, age_cap);
      age_cmp <= age_step(t1_compare_flag, age_cmp);
      age_ovf1 <= age_step(t1_overflow_flag, age_ovf1);
      age_ovf0 <= age_step(t0_overflow_flag, age_ovf0);
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_irq_enables <= `RESET_BYTE;
    end else if (clk_en && wr_pin_en) begin
      pin_irq_enables <= reg_wdata & `PIN_MASK_BITS;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      timer_irq_enables <= `RESET_BYTE;
    end else if (clk_en && wr_tmr_en) begin
      timer_irq_enables <= reg_wdata & `TIMER_MASK_BITS;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mcu_control_reg <= `RESET_BYTE;
    end else if (clk_en && wr_mcu) begin
      mcu_control_reg <= reg_wdata & `MCU_CTRL_BITS;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      global_enable <= 1'b0;
    end else if (clk_en) begin
      if (accept) begin
        global_enable <= 1'b0;
      end else if (return_from_irq_instr) begin
        global_enable <= 1'b1;
      end else if (wr_status) begin
        global_enable <= reg_wdata[`BIT_GIE];
      end
    end
  end

  // pin 0 flag; set wins over clear
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_req0_flag <= 1'b0;
    end else if (clk_en) begin
      if (lvl0) begin
        ext_req0_flag <= 1'b0;
      end else if (edge0) begin
        ext_req0_flag <= 1'b1;
      end else if (clr_ext0) begin
        ext_req0_flag <= 1'b0;
      end
    end
  end

  // pin 1 flag; set wins over clear
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_req1_flag <= 1'b0;
    end else if (clk_en) begin
      if (lvl1) begin
        ext_req1_flag <= 1'b0;
      end else if (edge1) begin
        ext_req1_flag <= 1'b1;
      end else if (clr_ext1) begin
        ext_req1_flag <= 1'b0;
      end
    end
  end

  // capture flag set regardless of mask
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      t1_capture_flag <= 1'b0;
    end else if (clk_en) begin
      if (t1_capture_evt) begin
        t1_capture_flag <= 1'b1;
      end else if (clr_cap) begin
        t1_capture_flag <= 1'b0;
      end
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      t1_compare_flag <= 1'b0;
    end else if (clk_en) begin
      if (t1_compare_evt) begin
        t1_compare_flag <= 1'b1;
      end else if (clr_cmp) begin
        t1_compare_flag <= 1'b0;
      end
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      t1_overflow_flag <= 1'b0;
    end else if (clk_en) begin
      if (t1_overflow_evt) begin
        t1_overflow_flag <= 1'b1;
      end else if (clr_ovf1) begin
        t1_overflow_flag <= 1'b0;
      end
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      t0_overflow_flag <= 1'b0;
    end else if (clk_en) begin
      if (t0_overflow_evt) begin
        t0_overflow_flag <= 1'b1;
      end else if (clr_ovf0) begin
        t0_overflow_flag <= 1'b0;
      end
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      core_irq_req <= 1'b0;
    end else if (clk_en) begin
      if (accept) begin
        core_irq_req <= 1'b0;
      end else if (!core_irq_req && next_req) begin
        core_irq_req <= 1'b1;
      end
    end
  end

  // vector latched only with a new request
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      core_irq_vector <= 4'h0;
    end else if (clk_en && !core_irq_req && next_req) begin
      core_irq_vector <= next_vector;
    end
  end

  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `ADDR_PIN_IRQ_ENABLES) begin
        next_rdata = pin_irq_enables;
      end else if (reg_addr == `ADDR_PIN_IRQ_FLAGS) begin
        next_rdata = pin_flag_view;
      end else if (reg_addr == `ADDR_TIMER_IRQ_ENABLES) begin
        next_rdata = timer_irq_enables;
      end else if (reg_addr == `ADDR_TIMER_IRQ_FLAG_REG) begin
        next_rdata = tmr_flag_view;
      end else if (reg_addr == `ADDR_MCU_CONTROL_REG) begin
        next_rdata = mcu_control_reg;
      end else if (reg_addr == `ADDR_CPU_STATUS_REG) begin
        next_rdata = status_view;
      end
    end
  end

  // Read data stands one cycle, zero otherwise
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ### test/irq_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Request side
  input wire logic core_irq_req,
  input wire logic [3:0] core_irq_vector,
  input wire logic [3:0] ack_wait,
  output logic core_irq_ack,
  output logic taken,
  output logic [3:0] taken_vec
);
  logic [3:0] waited;
  // Acknowledge after a programmable stall
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      core_irq_ack <= 1'b0;
      taken <= 1'b0;
      taken_vec <= 4'h0;
      waited <= 4'h0;
    end else begin
      core_irq_ack <= 1'b0;
      taken <= 1'b0;
      if (core_irq_req && !core_irq_ack) begin
        waited <= waited + 4'h1;
        if (waited >= ack_wait) begin
          core_irq_ack <= 1'b1;
          taken <= 1'b1;
          taken_vec <= core_irq_vector;
          waited <= 4'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/pin_and_timer_irq_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_chk #(
  parameter ADDR_W = 6
) (
  // Clock and register port
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Events and core link
  input wire logic t0_overflow_evt,
  input wire logic core_irq_ack,
  input wire logic core_irq_req,
  input wire logic [3:0] core_irq_vector
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence waiting;
    core_irq_req && !core_irq_ack;
  endsequence
  sequence ack_taken;
    core_irq_req && core_irq_ack && clk_en;
  endsequence
  AST_REQ_HOLD: assert property (waiting |=> core_irq_req)
    else $error("request dropped early");
  AST_VEC_HOLD: assert property (
    waiting |=> $stable(core_irq_vector))
    else $error("vector moved");
  AST_ACK_DROP: assert property (ack_taken |=> !core_irq_req [*2])
    else $error("request after acknowledge");
  AST_VEC_RANGE: assert property (
    core_irq_req |-> core_irq_vector inside {[4'h1:4'h6]})
    else $error("vector out of range");
  AST_RESPONSE: assert property (
    $rose(core_irq_req) && core_irq_vector == 4'h6 |->
    !($past(t0_overflow_evt, 1) || $past(t0_overflow_evt, 2) ||
      $past(t0_overflow_evt, 3) || $past(t0_overflow_evt, 4)))
    else $error("vector too soon");
  AST_PIN_RSVD: assert property (
    $past(reg_rd && clk_en && reg_addr[5:1] == 5'h1D) |->
    reg_rdata[5:0] == 6'h00)
    else $error("pin reserved bits set");
  AST_TMR_RSVD: assert property (
    $past(reg_rd && clk_en && reg_addr == 6'h39) |->
    (reg_rdata & 8'h35) == 8'h00)
    else $error("timer reserved bits set");
  AST_RD_IDLE: assert property (
    $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule
bind pin_and_timer_irq_control irq_ctrl_chk #(.ADDR_W(ADDR_W)) chk (
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .t0_overflow_evt(t0_overflow_evt), .core_irq_ack(core_irq_ack),
  .core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector));
`default_nettype wire

// ### test/pin_and_timer_irq_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pin_and_timer_irq_control_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic pin0 = 1'b1;
  logic pin1 = 1'b1;
  logic [3:0] evt = 4'h0;
  logic ret = 1'b0;
  logic bound = 1'b1;
  logic ack, req, taken;
  logic [3:0] vec, taken_vec;
  logic [3:0] ack_wait = 4'h0;
  int fails = 0;
  int compares = 0;
  initial begin
    forever #10 clock = ~clock;
  end
  pin_and_timer_irq_control dut (.clock(clock), .sys_rst(sys_rst),
    .clk_en(clk_en), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata(rdata), .ext_pin0(pin0), .ext_pin1(pin1),
    .t1_overflow_evt(evt[3]), .t1_compare_evt(evt[2]),
    .t1_capture_evt(evt[1]), .t0_overflow_evt(evt[0]),
    .core_irq_ack(ack), .return_from_irq_instr(ret),
    .instr_boundary(bound), .core_irq_req(req), .core_irq_vector(vec));
  irq_core_model core (.clock(clock), .sys_rst(sys_rst),
    .core_irq_req(req), .core_irq_vector(vec), .ack_wait(ack_wait),
    .core_irq_ack(ack), .taken(taken), .taken_vec(taken_vec));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulse(input logic [3:0] m, input logic r);
    @(posedge clock);
    evt <= m;
    ret <= r;
    @(posedge clock);
    evt <= 4'h0;
    ret <= 1'b0;
  endtask
  task automatic serve(input logic [3:0] v);
    int n;
    for (n = 0; n < 60 && taken !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    chk({3'h0, taken, taken_vec}, {4'h1, v});
    repeat (5) @(posedge clock);
    #1 chk({7'h0, req}, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    rd(6'h39, 8'h00);
    rd(6'h10, 8'h00);
    pulse(4'h1, 1'b0);
    rd(6'h38, 8'h02);
    wr(6'h38, 8'h02);
    rd(6'h38, 8'h00);
    wr(6'h39, 8'hFF);
    rd(6'h39, 8'hCA);
    wr(6'h3B, 8'hFF);
    rd(6'h3B, 8'hC0);
    pulse(4'hF, 1'b0);
    rd(6'h38, 8'hCA);
    #1 chk({7'h0, req}, 8'h00);
    bound <= 1'b0;
    ack_wait <= 4'h3;
    wr(6'h3F, 8'h80);
    repeat (10) @(posedge clock);
    #1 chk({7'h0, req}, 8'h00);
    bound <= 1'b1;
    serve(4'h3);
    pulse(4'h0, 1'b1);
    serve(4'h4);
    pulse(4'h0, 1'b1);
    serve(4'h5);
    pulse(4'h0, 1'b1);
    serve(4'h6);
    rd(6'h38, 8'h00);
    ack_wait <= 4'h0;
    wr(6'h35, 8'h0E);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    repeat (3) @(posedge clock);
    pin1 <= 1'b1;
    repeat (3) @(posedge clock);
    rd(6'h3A, 8'hC0);
    wr(6'h3A, 8'hC0);
    rd(6'h3A, 8'h00);
    pin0 <= 1'b1;
    pin1 <= 1'b0;
    repeat (3) @(posedge clock);
    pin0 <= 1'b0;
    pin1 <= 1'b1;
    pulse(4'h0, 1'b1);
    serve(4'h1);
    pulse(4'h0, 1'b1);
    serve(4'h2);
    wr(6'h35, 8'h0C);
    rd(6'h3A, 8'h00);
    pulse(4'h0, 1'b1);
    serve(4'h1);
    pin0 <= 1'b1;
    pulse(4'h0, 1'b1);
    repeat (10) @(posedge clock);
    #1 chk({7'h0, req}, 8'h00);
    clk_en <= 1'b0;
    pulse(4'h1, 1'b0);
    clk_en <= 1'b1;
    rd(6'h38, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
